// ===== rtl/pdd_dialer_port.v
// Parallel digit dialer port, adapter side, with Avalon-MM registers.
`timescale 1ns/100ps
`default_nettype none
`include "pdd_regs.vh"

module pdd_dialer_port #(
    parameter        PORT_NUM   = 3,
    parameter [31:0] TIMEOUT_CY = `PDD_TIMEOUT_MS * `PDD_CLK_KHZ,
    parameter        MAX_DIGITS = `PDD_MAX_DIGITS
) (
    // Clock and reset.
    input  wire        clk_i,
    input  wire        rst_i,
    // Avalon-MM slave.
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output reg  [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    // DTE dial leads.
    input  wire        call_request_line_i,
    input  wire        digit_valid_strobe_i,
    input  wire        digit_lead_weight_one_i,
    input  wire        digit_lead_weight_two_i,
    input  wire        digit_lead_weight_four_i,
    input  wire        digit_lead_weight_eight_i,
    output wire        dialer_powered_flag_o,
    output reg         line_occupied_flag_o,
    output reg         next_digit_request_o,
    output reg         abandon_retry_flag_o,
    output reg         far_station_connected_o,
    // Data port call control.
    output reg         call_start_o,
    output wire [1:0]  data_port_sel_o,
    output reg         call_abort_o,
    input  wire        data_port_busy_i
);

    // States.
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_WAIT = 3'd1;
    localparam [2:0] ST_LTCH = 3'd2;
    localparam [2:0] ST_CALL = 3'd3;
    localparam [2:0] ST_CONN = 3'd4;
    localparam [2:0] ST_ABAN = 3'd5;
    localparam [2:0] ST_HOLD = 3'd6;

    //////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    // Codes 0..11 are digits, 12 is the terminator, others are dropped.
    function is_dial_code;
        input [3:0] c;
        begin
            is_dial_code = (c <= `PDD_CODE_HASH);
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    reg [1:0] crq_s_r;
    reg [1:0] dpr_s_r;
    reg [3:0] lead_a_r;
    reg [3:0] lead_b_r;
    reg       dpr_d_r;

    // Two stages per input; the second stage feeds logic, and a third strobe stage feeds the edge detect.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            crq_s_r  <= 2'b00;
            dpr_s_r  <= 2'b00;
            lead_a_r <= 4'h0;
            lead_b_r <= 4'h0;
            dpr_d_r  <= 1'b0;
        end else begin
            crq_s_r  <= {crq_s_r[0], call_request_line_i};
            dpr_s_r  <= {dpr_s_r[0], digit_valid_strobe_i};
            lead_a_r <= {digit_lead_weight_eight_i, digit_lead_weight_four_i,
                         digit_lead_weight_two_i, digit_lead_weight_one_i};
            lead_b_r <= lead_a_r;
            dpr_d_r  <= dpr_s_r[1];
        end
    end

    wire call_request_line      = crq_s_r[1];
    wire digit_valid_strobe      = dpr_s_r[1];
    wire dpr_rise = digit_valid_strobe & ~dpr_d_r;

    //////////////////////////////////////////////////////////////////////////
    // Control registers.

    reg [7:0]  ctrl_r;
    reg        conn_evt_r;
    reg        fail_evt_r;
    reg        disc_evt_r;
    wire       nailed = ctrl_r[`PDD_CTRL_NAILED];

    // The slave answers in the same cycle, so waitrequest stays low.
    assign avs_waitrequest_o = 1'b0;

    // Write side: connect, fail and disconnect bits are self-clearing.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_r     <= `PDD_CTRL_RESET;
            conn_evt_r <= 1'b0;
            fail_evt_r <= 1'b0;
            disc_evt_r <= 1'b0;
        end else begin
            conn_evt_r <= 1'b0;
            fail_evt_r <= 1'b0;
            disc_evt_r <= 1'b0;
            if (avs_write_i && avs_address_i == `PDD_OFF_CTRL) begin
                ctrl_r[0]  <= avs_writedata_i[`PDD_CTRL_NAILED];
                conn_evt_r <= avs_writedata_i[`PDD_CTRL_CONNECT];
                fail_evt_r <= avs_writedata_i[`PDD_CTRL_FAIL];
                disc_evt_r <= avs_writedata_i[`PDD_CTRL_DISC];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Dial state machine.

    reg [2:0]  st_r;
    reg [5:0]  cnt_r;
    reg [31:0] tmr_r;
    reg [3:0]  last_r;
    reg        store_wr_r;
    reg [5:0]  rd_idx_r;
    wire [3:0] rd_code;

    // Dialer port 4 serves data port 2; any other port number serves data port 1.
    assign data_port_sel_o = (PORT_NUM == 4) ? 2'd2 : 2'd1;

    // Power indication is tied high as the logic is powered.
    assign dialer_powered_flag_o = 1'b1;

    // Main sequencer.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r                    <= ST_IDLE;
            cnt_r                   <= 6'd0;
            tmr_r                   <= 32'd0;
            last_r                  <= 4'h0;
            store_wr_r              <= 1'b0;
            line_occupied_flag_o    <= 1'b0;
            next_digit_request_o    <= 1'b0;
            abandon_retry_flag_o    <= 1'b0;
            far_station_connected_o <= 1'b0;
            call_start_o            <= 1'b0;
            call_abort_o            <= 1'b0;
        end else begin
            call_start_o <= 1'b0;
            call_abort_o <= 1'b0;
            store_wr_r   <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    line_occupied_flag_o    <= data_port_busy_i;
                    next_digit_request_o    <= 1'b0;
                    abandon_retry_flag_o    <= 1'b0;
                    far_station_connected_o <= 1'b0;
                    cnt_r                   <= 6'd0;
                    if (call_request_line && !data_port_busy_i) begin
                        line_occupied_flag_o <= 1'b1;
                        next_digit_request_o <= 1'b1;
                        tmr_r                <= 32'd0;
                        st_r                 <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    tmr_r <= tmr_r + 32'd1;
                    if (!call_request_line) begin
                        st_r <= ST_IDLE;
                    end else if (dpr_rise) begin
                        next_digit_request_o <= 1'b0;
                        last_r               <= lead_b_r;
                        st_r                 <= ST_LTCH;
                    end else if (tmr_r >= TIMEOUT_CY - 32'd1) begin
                        next_digit_request_o <= 1'b0;
                        if (cnt_r == 6'd0) begin
                            abandon_retry_flag_o <= 1'b1;
                            st_r                 <= ST_ABAN;
                        end else begin
                            call_start_o <= 1'b1;
                            st_r         <= ST_CALL;
                        end
                    end
                end
                ST_LTCH: begin
                    // Wait for the strobe to drop before asking again.
                    if (!call_request_line) begin
                        st_r <= ST_IDLE;
                    end else if (!digit_valid_strobe) begin
                        if (last_r == `PDD_CODE_EON) begin
                            if (nailed) begin
                                far_station_connected_o <= 1'b1;
                                st_r <= ST_CONN;
                            end else begin
                                call_start_o <= 1'b1;
                                st_r         <= ST_CALL;
                            end
                        end else if (is_dial_code(last_r) &&
                                     cnt_r == MAX_DIGITS) begin
                            abandon_retry_flag_o <= 1'b1;
                            st_r                 <= ST_ABAN;
                        end else begin
                            if (is_dial_code(last_r)) begin
                                store_wr_r <= 1'b1;
                                cnt_r      <= cnt_r + 6'd1;
                            end
                            next_digit_request_o <= 1'b1;
                            tmr_r                <= 32'd0;
                            st_r                 <= ST_WAIT;
                        end
                    end
                end
                ST_CALL: begin
                    if (!call_request_line) begin
                        call_abort_o <= 1'b1;
                        st_r         <= ST_IDLE;
                    end else if (conn_evt_r) begin
                        far_station_connected_o <= 1'b1;
                        st_r                    <= ST_CONN;
                    end else if (fail_evt_r) begin
                        abandon_retry_flag_o <= 1'b1;
                        st_r                 <= ST_ABAN;
                    end
                end
                ST_CONN: begin
                    // Dropping call request only lowers the connected flag.
                    if (!call_request_line) begin
                        far_station_connected_o <= 1'b0;
                    end
                    if (disc_evt_r) begin
                        st_r <= call_request_line ? ST_HOLD : ST_IDLE;
                    end
                end
                ST_HOLD: begin
                    if (!call_request_line) begin
                        far_station_connected_o <= 1'b0;
                        st_r                    <= ST_IDLE;
                    end
                end
                ST_ABAN: begin
                    if (!call_request_line) begin
                        abandon_retry_flag_o <= 1'b0;
                        st_r                 <= ST_IDLE;
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Digit store and read path.

    // Stored code is written one cycle after acceptance at old count.
    pdd_digit_store #(
        .DEPTH (MAX_DIGITS),
        .AW    (6)
    ) u_store (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_i      (store_wr_r),
        .wr_idx_i  (cnt_r - 6'd1),
        .wr_code_i (last_r),
        .rd_idx_i  (rd_idx_r),
        .rd_code_o (rd_code)
    );

    // The digit index register selects which stored digit reads back.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_idx_r <= 6'd0;
        end else if (avs_write_i && avs_address_i == `PDD_OFF_DIGIT) begin
            rd_idx_r <= avs_writedata_i[5:0];
        end
    end

    // Read mux; unmapped offsets and cycles without a read return zero.
    always @* begin
        avs_readdata_o = 32'h0;
        if (avs_read_i) begin
            case (avs_address_i)
                `PDD_OFF_CTRL:   avs_readdata_o = {24'h0, ctrl_r};
                `PDD_OFF_STATUS: avs_readdata_o = {21'h0, st_r, call_request_line, digit_valid_strobe,
                                     far_station_connected_o,
                                     abandon_retry_flag_o,
                                     next_digit_request_o,
                                     line_occupied_flag_o, 2'b00};
                `PDD_OFF_DIGIT:  avs_readdata_o = {22'h0, rd_idx_r, rd_code};
                `PDD_OFF_COUNT:  avs_readdata_o = {26'h0, cnt_r};
                default:         avs_readdata_o = 32'h0;
            endcase
        end
    end

endmodule // pdd_dialer_port

`default_nettype wire

// ===== rtl/pdd_digit_store.v
// Digit store of the parallel digit dialer port.
`timescale 1ns/100ps
`default_nettype none

module pdd_digit_store #(
    parameter DEPTH = 40,
    parameter AW    = 6
) (
    // Clock and reset.
    input  wire          clk_i,
    input  wire          rst_i,
    // Write side.
    input  wire          wr_i,
    input  wire [AW-1:0] wr_idx_i,
    input  wire [3:0]    wr_code_i,
    // Read side.
    input  wire [AW-1:0] rd_idx_i,
    output reg  [3:0]    rd_code_o
);

    // Digit memory; no reset is needed since count gates its use.
    reg [3:0] mem [0:DEPTH-1];

    // Store collected digits.
    always @(posedge clk_i) begin
        if (wr_i) begin
            mem[wr_idx_i] <= wr_code_i;
        end
    end

    // Registered read port.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_code_o <= 4'h0;
        end else begin
            rd_code_o <= mem[rd_idx_i];
        end
    end

endmodule // pdd_digit_store

`default_nettype wire

// ===== rtl/pdd_regs.vh
// Constants for the parallel digit dialer port.
`ifndef PDD_REGS_VH
`define PDD_REGS_VH

// Register byte offsets on the Avalon-MM slave.
`define PDD_OFF_CTRL       4'h0
`define PDD_OFF_STATUS     4'h4
`define PDD_OFF_DIGIT      4'h8
`define PDD_OFF_COUNT      4'hc

// Control register fields.
`define PDD_CTRL_NAILED    0
`define PDD_CTRL_CONNECT   1
`define PDD_CTRL_FAIL      2
`define PDD_CTRL_DISC      3
`define PDD_CTRL_RESET     8'h00

// Digit codes on the weighted leads.
`define PDD_CODE_STAR      4'ha
`define PDD_CODE_HASH      4'hb
`define PDD_CODE_EON       4'hc

// Digit limit and timeout.
`define PDD_MAX_DIGITS     40
`define PDD_TIMEOUT_MS     5000
`define PDD_CLK_KHZ        25000

`endif

// ===== testbench/pdd_checker_props.sv
// Assertion checker watching the dialer port from its top-level ports.
`timescale 1ns/100ps
`default_nettype none
module pdd_checker #(
    parameter        PORT_NUM   = 3,
    parameter [31:0] TIMEOUT_CY = 200,
    parameter        MAX_DIGITS = 40
) (
    // Clock and reset.
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Dial leads from the DTE.
    input wire logic       call_request_line_i,
    input wire logic       digit_valid_strobe_i,
    // Dialer answers.
    input wire logic       dialer_powered_flag_o,
    input wire logic       line_occupied_flag_o,
    input wire logic       next_digit_request_o,
    input wire logic       abandon_retry_flag_o,
    input wire logic       far_station_connected_o,
    input wire logic       call_start_o,
    input wire logic [1:0] data_port_sel_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    power_high_a: assert property (dialer_powered_flag_o)
        else $error("power flag low");
    port_bind_a: assert property (
        data_port_sel_o == (PORT_NUM == 3 ? 2'd1 : 2'd2))
        else $error("wrong data port bound");
    occ_next_a: assert property (
        next_digit_request_o |-> line_occupied_flag_o)
        else $error("digit request without occupied");
    next_drop_a: assert property (
        $rose(digit_valid_strobe_i) && next_digit_request_o
        |-> ##[1:5] !next_digit_request_o)
        else $error("next digit request not dropped");
    req_drop_a: assert property (
        $fell(call_request_line_i)
        |-> ##[1:6] (!next_digit_request_o && !abandon_retry_flag_o
                     && !far_station_connected_o))
        else $error("outputs not idle after request drop");
    abandon_hold_a: assert property (
        abandon_retry_flag_o && call_request_line_i
        && $past(call_request_line_i, 3) |=> abandon_retry_flag_o)
        else $error("abandon dropped while requested");
    conn_hold_a: assert property (
        far_station_connected_o && call_request_line_i
        && $past(call_request_line_i, 3) |=> far_station_connected_o)
        else $error("connected dropped while requested");
    start_pulse_a: assert property (
        call_start_o |-> line_occupied_flag_o ##1 !call_start_o)
        else $error("call start not a single pulse");
endmodule // pdd_checker

bind pdd_dialer_port pdd_checker #(
    .PORT_NUM   (PORT_NUM),
    .TIMEOUT_CY (TIMEOUT_CY),
    .MAX_DIGITS (MAX_DIGITS)
) i_chk (
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .call_request_line_i     (call_request_line_i),
    .digit_valid_strobe_i    (digit_valid_strobe_i),
    .dialer_powered_flag_o   (dialer_powered_flag_o),
    .line_occupied_flag_o    (line_occupied_flag_o),
    .next_digit_request_o    (next_digit_request_o),
    .abandon_retry_flag_o    (abandon_retry_flag_o),
    .far_station_connected_o (far_station_connected_o),
    .call_start_o            (call_start_o),
    .data_port_sel_o         (data_port_sel_o)
);
`default_nettype wire

// ===== testbench/pdd_dte_model.sv
// Behavioural DTE that raises call request and presents digits.
`timescale 1ns/100ps
`default_nettype none
module pdd_dte_model (
    // Clock and dialer answer.
    input  wire logic       clk_i,
    input  wire logic       next_i,
    // Dial leads.
    output var  logic       crq_o,
    output var  logic       stb_o,
    output var  logic [3:0] lead_o,
    output var  int         fails
);
    // Everything idle until the bench asks for a call.
    initial begin
        crq_o = 1'b0;
        stb_o = 1'b0;
        lead_o = 4'h0;
        fails = 0;
    end
    // Request is held for the whole origination; bench raises it when idle.
    task automatic request(input logic v);
        @(posedge clk_i);
        crq_o <= v;
    endtask
    // One digit handshake; a stuck dialer is counted, never waited on forever.
    task automatic digit(input logic [3:0] c);
        int i;
        for (i = 0; i < 400 && next_i !== 1'b1; i++) @(posedge clk_i);
        if (i == 400) fails++;
        @(posedge clk_i);
        lead_o <= c;
        repeat (4) @(posedge clk_i);
        stb_o <= 1'b1;
        for (i = 0; i < 40 && next_i !== 1'b0; i++) @(posedge clk_i);
        if (i == 40) fails++;
        stb_o <= 1'b0;
        lead_o <= ~c; // Stale code is not kept, so a late read shows garbage.
    endtask
endmodule // pdd_dte_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking testbench for the parallel digit dialer port.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  adr   = 4'h0;
    logic        re    = 1'b0;
    logic        we    = 1'b0;
    logic [31:0] wd    = 32'h0;
    logic        busy  = 1'b0;
    logic [31:0] v;
    wire  [31:0] rdata;
    wire         wreq, pwr, occ, nxt, abn, conn, start, abort, call_request_line, stb;
    wire  [1:0]  sel;
    wire  [3:0]  ld;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          n_start = 0;
    int          n_abort = 0;
    int          dte_fails;
    int          exp_q[$];
    // Clock and pulse counters; pulses last one cycle so count at the edge.
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n_start <= n_start + int'(start);
        n_abort <= n_abort + int'(abort);
    end
    ////////////////////////////////////////////////////////////////////////
    pdd_dialer_port #(
        .TIMEOUT_CY (32'd200)
    ) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(re),
        .avs_write_i(we), .avs_writedata_i(wd), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .call_request_line_i(call_request_line),
        .digit_valid_strobe_i(stb), .digit_lead_weight_one_i(ld[0]),
        .digit_lead_weight_two_i(ld[1]), .digit_lead_weight_four_i(ld[2]),
        .digit_lead_weight_eight_i(ld[3]), .dialer_powered_flag_o(pwr),
        .line_occupied_flag_o(occ), .next_digit_request_o(nxt),
        .abandon_retry_flag_o(abn), .far_station_connected_o(conn),
        .call_start_o(start), .data_port_sel_o(sel), .call_abort_o(abort),
        .data_port_busy_i(busy));
    pdd_dte_model i_dte (.clk_i(clk_i), .next_i(nxt), .crq_o(call_request_line),
        .stb_o(stb), .lead_o(ld), .fails(dte_fails));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        we <= 1'b1;
        do @(posedge clk_i); while (wreq !== 1'b0);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        adr <= a;
        re <= 1'b1;
        do @(posedge clk_i); while (wreq !== 1'b0);
        v = rdata;
        re <= 1'b0;
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return nxt;
            1: return conn;
            2: return abn;
            default: return occ;
        endcase
    endfunction
    // Waits are sampled mid-cycle so a level never races its own edge.
    task automatic wait_lvl(input int s, input logic l, input string nm);
        for (int i = 0; i < 600 && sig(s) !== l; i++) @(negedge clk_i);
        chk(nm, sig(s), l);
    endtask
    task automatic dial(input int n);
        int c;
        repeat (n) begin
            c = $urandom % 12;
            exp_q.push_back(c);
            i_dte.digit(c[3:0]);
        end
    endtask
    // Reference model: the queue holds every code the store should keep.
    task automatic verify();
        rd(4'hc);
        chk("count", v[5:0], exp_q.size());
        foreach (exp_q[i]) begin
            wr(4'h8, i);
            rd(4'h8);
            chk("digit", v[3:0], exp_q[i]);
        end
        exp_q.delete();
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog sized well beyond the longest expected run.
    initial begin
        #(40 * 40000);
        error_cnt++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int c;
        int es;
        void'($urandom(50));
        es = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("power", pwr, 1);
        chk("port", sel, 2'h1);
        // Ordinary call: digits, a dropped bad code, timeout, connect.
        i_dte.request(1'b1);
        wait_lvl(3, 1, "occupied");
        wait_lvl(0, 1, "next");
        dial(5);
        c = 13 + $urandom % 3;
        i_dte.digit(c[3:0]);
        repeat (260) @(posedge clk_i);
        es++;
        chk("start", n_start, es);
        verify();
        wr(4'h0, 32'h2);
        wait_lvl(1, 1, "connected");
        i_dte.request(1'b0);
        wait_lvl(1, 0, "conn drop");
        wr(4'h0, 32'h8);
        $display("test ordinary done");
        // Nailed-up line ends on the terminator and connects at once.
        wr(4'h0, 32'h1);
        i_dte.request(1'b1);
        dial(2);
        i_dte.digit(4'hc);
        wait_lvl(1, 1, "nailed conn");
        chk("no start", n_start, es);
        verify();
        wr(4'h0, 32'h9);
        repeat (4) @(negedge clk_i);
        chk("hold conn", conn, 1);
        i_dte.request(1'b0);
        wait_lvl(1, 0, "nailed drop");
        wr(4'h0, 32'h0);
        $display("test nailed done");
        // Empty number times out into abandon, held until request drops.
        i_dte.request(1'b1);
        wait_lvl(2, 1, "empty abandon");
        repeat (20) @(negedge clk_i);
        chk("abandon hold", abn, 1);
        i_dte.request(1'b0);
        wait_lvl(2, 0, "abandon drop");
        $display("test empty done");
        // One digit beyond the limit abandons.
        i_dte.request(1'b1);
        dial(41);
        wait_lvl(2, 1, "overflow");
        void'(exp_q.pop_back());
        verify();
        i_dte.request(1'b0);
        wait_lvl(2, 0, "overflow drop");
        $display("test overflow done");
        // Request dropped while calling aborts; failed call abandons.
        for (int k = 0; k < 2; k++) begin
            repeat (4) @(posedge clk_i);
            i_dte.request(1'b1);
            dial(1);
            exp_q.delete();
            repeat (260) @(posedge clk_i);
            es++;
            chk("start", n_start, es);
            if (k == 1) begin
                wr(4'h0, 32'h4);
                wait_lvl(2, 1, "fail abandon");
            end
            i_dte.request(1'b0);
            repeat (8) @(posedge clk_i);
            chk("abort", n_abort, 1);
            wait_lvl(3, 0, "idle occupied");
        end
        $display("test abort done");
        // Busy data port shows occupied and refuses a call.
        @(posedge clk_i);
        busy <= 1'b1;
        wait_lvl(3, 1, "busy occupied");
        i_dte.request(1'b1);
        repeat (10) @(posedge clk_i);
        chk("busy next", nxt, 0);
        i_dte.request(1'b0);
        busy <= 1'b0;
        wait_lvl(3, 0, "busy free");
        chk("dte", dte_fails, 0);
        $display("test busy done");
        results();
    end
endmodule // tb_top
`default_nettype wire
